// ==== ocd_pkg.sv ====
// package: register map, field positions, stage config and helpers for the output channel dividers
package ocd_pkg;

   // ==========================================================================
   // register indices (byte address is four times the index)
   // ==========================================================================
   localparam logic [11:0] IDX_PECL1_COUNTS = 12'h196;
   localparam logic [11:0] IDX_PECL1_CTRL = 12'h197;
   localparam logic [11:0] IDX_PECL1_ROUTE = 12'h198;
   localparam logic [11:0] IDX_C2_S1_COUNTS = 12'h199;
   localparam logic [11:0] IDX_C2_PHASE = 12'h19a;
   localparam logic [11:0] IDX_C2_S2_COUNTS = 12'h19b;
   localparam logic [11:0] IDX_C2_CTRL = 12'h19c;
   localparam logic [11:0] IDX_C2_DCC = 12'h19d;
   localparam logic [11:0] IDX_C3_S1_COUNTS = 12'h19e;
   localparam logic [11:0] IDX_SRC_SEL = 12'h1e1;

   // ==========================================================================
   // reset values
   // ==========================================================================
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [1:0] RST_SRC_SEL = 2'h0;

   // ==========================================================================
   // field positions
   // ==========================================================================
   localparam int PECL_BYPASS_BIT = 7;
   localparam int PECL_NOSYNC_BIT = 6;
   localparam int PECL_FORCE_BIT = 5;
   localparam int PECL_START_BIT = 4;
   localparam int ROUTE_DIRECT_BIT = 1;
   localparam int DCC_OFF_BIT = 0;
   localparam int C2_BYPASS2_BIT = 5;
   localparam int C2_BYPASS1_BIT = 4;
   localparam int C2_NOSYNC_BIT = 3;
   localparam int C2_FORCE_BIT = 2;
   localparam int C2_START2_BIT = 1;
   localparam int C2_START1_BIT = 0;
   localparam int UPPER_LSB = 4;
   localparam int LOWER_LSB = 0;

   // ==========================================================================
   // direct route source codes
   // ==========================================================================
   localparam logic [1:0] SRC_OSC = 2'h2;
   localparam logic [1:0] SRC_EXT = 2'h0;
   localparam logic [1:0] SRC_NONE = 2'h1;

   // ==========================================================================
   // types
   // ==========================================================================
   typedef enum logic [1:0] {stage_hold, stage_delay, stage_run} ocd_stage_e;

   typedef struct packed {
      logic [3:0] lo;
      logic [3:0] hi;
      logic [3:0] phase;
      logic bypass;
      logic start_hi;
      logic dcc_on;
   } ocd_stage_cfg_s;

   // ==========================================================================
   // helpers
   // ==========================================================================
   // nibble extraction, used for the pecl and channel two count and phase fields
   function automatic logic [3:0] upper_nib(input logic [7:0] v);
      upper_nib = v[UPPER_LSB +: 4];
   endfunction

   function automatic logic [3:0] lower_nib(input logic [7:0] v);
      lower_nib = v[LOWER_LSB +: 4];
   endfunction

   // high-phase terminal count; with correction on the period splits in half
   function automatic logic [4:0] high_limit(input logic [3:0] lo, input logic [3:0] hi,
                                             input logic dcc);
      logic [5:0] total;
      total = 6'({2'h0, lo}) + 6'({2'h0, hi}) + 6'h02;
      high_limit = dcc ? 5'((total >> 1) - 6'h01) : {1'b0, hi};
   endfunction

   // low-phase terminal count, the remainder of the period
   function automatic logic [4:0] low_limit(input logic [3:0] lo, input logic [3:0] hi,
                                            input logic dcc);
      logic [5:0] total;
      total = 6'({2'h0, lo}) + 6'({2'h0, hi}) + 6'h02;
      low_limit = dcc ? 5'(total - (total >> 1) - 6'h01) : {1'b0, lo};
   endfunction

endpackage

// ==== ocd_top.sv ====
// output channel dividers: apb register file, divider stages and output pair routing

// ============================================================================
// one divider stage
// ============================================================================
module ocd_div_stage (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tick_in,
   input wire logic lvl_in,
   input wire logic sync_hold,
   input wire logic force_on,
   input wire logic force_lvl,
   input wire ocd_pkg::ocd_stage_cfg_s cfg,
   output logic lvl_out,
   output logic tick_out
);

   ocd_pkg::ocd_stage_e state;
   ocd_pkg::ocd_stage_e next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [3:0] pcnt;
   logic [3:0] next_pcnt;
   logic next_lvl;
   logic next_tick;
   wire logic [4:0] hi_lim;
   wire logic [4:0] lo_lim;
   wire logic [4:0] cur_lim;

   // terminal counts for the present level, corrected when asked
   assign hi_lim = ocd_pkg::high_limit(cfg.lo, cfg.hi, cfg.dcc_on);
   assign lo_lim = ocd_pkg::low_limit(cfg.lo, cfg.hi, cfg.dcc_on);
   assign cur_lim = lvl_out ? hi_lim : lo_lim;

   // next-state logic; bypass, force and sync override the counter
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_pcnt = pcnt;
      next_lvl = lvl_out;
      next_tick = 1'b0;
      if (cfg.bypass) begin
         // counter idles, so the divider logic is effectively powered down
         next_lvl = lvl_in;
         next_tick = tick_in;
         next_state = ocd_pkg::stage_hold;
         next_cnt = 5'h00;
      end else if (force_on) begin
         next_lvl = force_lvl;
         next_state = ocd_pkg::stage_hold;
         next_cnt = 5'h00;
      end else if (sync_hold) begin
         next_lvl = cfg.start_hi;
         next_state = ocd_pkg::stage_hold;
         next_cnt = 5'h00;
      end else begin
         case (state)
            ocd_pkg::stage_hold: begin
               next_pcnt = cfg.phase;
               next_state = (cfg.phase == 4'h0) ? ocd_pkg::stage_run : ocd_pkg::stage_delay;
            end
            ocd_pkg::stage_delay: begin
               // start level is held while the offset counts down
               if (tick_in) begin
                  next_pcnt = pcnt - 4'h1;
                  if (pcnt == 4'h1) begin
                     next_state = ocd_pkg::stage_run;
                  end
               end
            end
            ocd_pkg::stage_run: begin
               if (tick_in) begin
                  if (cnt >= cur_lim) begin
                     next_lvl = ~lvl_out;
                     next_cnt = 5'h00;
                     next_tick = ~lvl_out;
                  end else begin
                     next_cnt = cnt + 5'h01;
                  end
               end
            end
            default: begin
               next_state = ocd_pkg::stage_hold;
            end
         endcase
      end
   end

   // stage registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ocd_pkg::stage_hold;
         cnt <= 5'h00;
         pcnt <= 4'h0;
         lvl_out <= 1'b0;
         tick_out <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         pcnt <= next_pcnt;
         lvl_out <= next_lvl;
         tick_out <= next_tick;
      end
   end

endmodule

// ============================================================================
// top: apb slave and channel wiring
// ============================================================================
module ocd_top #(
   parameter int ADDR_W = 14
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sync_req,
   input wire logic osc_in,
   input wire logic ext_in,
   output logic pair_b_true_output,
   output logic pair_b_comp_output,
   output logic chan2_clk_out,
   output logic chan2_stage1_out
);

   // ==========================================================================
   // register file
   // ==========================================================================
   logic [7:0] pecl_div1_counts;
   logic [7:0] pecl_div1_start_and_phase;
   logic [7:0] pecl_div1_route_and_duty;
   logic [7:0] chan2_stage1_counts;
   logic [7:0] chan2_phase_offsets;
   logic [7:0] chan2_stage2_counts;
   logic [7:0] chan2_control;
   logic [7:0] chan2_duty_correction;
   logic [7:0] chan3_stage1_counts;
   logic [1:0] src_select;
   logic dist_lvl;
   logic next_pair;

   wire logic [11:0] idx;
   wire logic access;
   wire logic wr_en;
   wire logic hit;
   wire logic [7:0] rd_byte;

   // one wait state: pready rises in the second access cycle
   assign idx = paddr[13:2];
   assign access = psel & penable & ~pready;
   assign wr_en = psel & penable & pready & pwrite & hit; // lands only at the completing edge
   assign hit = (idx == ocd_pkg::IDX_PECL1_COUNTS) || (idx == ocd_pkg::IDX_PECL1_CTRL) ||
                (idx == ocd_pkg::IDX_PECL1_ROUTE) || (idx == ocd_pkg::IDX_C2_S1_COUNTS) ||
                (idx == ocd_pkg::IDX_C2_PHASE) || (idx == ocd_pkg::IDX_C2_S2_COUNTS) ||
                (idx == ocd_pkg::IDX_C2_CTRL) || (idx == ocd_pkg::IDX_C2_DCC) ||
                (idx == ocd_pkg::IDX_C3_S1_COUNTS) || (idx == ocd_pkg::IDX_SRC_SEL);

   // read selection; unmapped words read zero
   assign rd_byte = (idx == ocd_pkg::IDX_PECL1_COUNTS) ? pecl_div1_counts :
                    (idx == ocd_pkg::IDX_PECL1_CTRL) ? pecl_div1_start_and_phase :
                    (idx == ocd_pkg::IDX_PECL1_ROUTE) ? pecl_div1_route_and_duty :
                    (idx == ocd_pkg::IDX_C2_S1_COUNTS) ? chan2_stage1_counts :
                    (idx == ocd_pkg::IDX_C2_PHASE) ? chan2_phase_offsets :
                    (idx == ocd_pkg::IDX_C2_S2_COUNTS) ? chan2_stage2_counts :
                    (idx == ocd_pkg::IDX_C2_CTRL) ? chan2_control :
                    (idx == ocd_pkg::IDX_C2_DCC) ? chan2_duty_correction :
                    (idx == ocd_pkg::IDX_C3_S1_COUNTS) ? chan3_stage1_counts :
                    (idx == ocd_pkg::IDX_SRC_SEL) ? {6'h00, src_select} : 8'h00;

   // apb answer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access & ~hit;
         prdata <= (access & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // register writes, byte taken from the low lane
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pecl_div1_counts <= ocd_pkg::RST_REG;
         pecl_div1_start_and_phase <= ocd_pkg::RST_REG;
         pecl_div1_route_and_duty <= ocd_pkg::RST_REG;
         chan2_stage1_counts <= ocd_pkg::RST_REG;
         chan2_phase_offsets <= ocd_pkg::RST_REG;
         chan2_stage2_counts <= ocd_pkg::RST_REG;
         chan2_control <= ocd_pkg::RST_REG;
         chan2_duty_correction <= ocd_pkg::RST_REG;
         chan3_stage1_counts <= ocd_pkg::RST_REG;
         src_select <= ocd_pkg::RST_SRC_SEL;
      end else if (wr_en) begin
         case (idx)
            ocd_pkg::IDX_PECL1_COUNTS: pecl_div1_counts <= pwdata[7:0];
            ocd_pkg::IDX_PECL1_CTRL: pecl_div1_start_and_phase <= pwdata[7:0];
            ocd_pkg::IDX_PECL1_ROUTE: pecl_div1_route_and_duty <= pwdata[7:0] & 8'h03;
            ocd_pkg::IDX_C2_S1_COUNTS: chan2_stage1_counts <= pwdata[7:0];
            ocd_pkg::IDX_C2_PHASE: chan2_phase_offsets <= pwdata[7:0];
            ocd_pkg::IDX_C2_S2_COUNTS: chan2_stage2_counts <= pwdata[7:0];
            ocd_pkg::IDX_C2_CTRL: chan2_control <= pwdata[7:0] & 8'h3f;
            ocd_pkg::IDX_C2_DCC: chan2_duty_correction <= pwdata[7:0] & 8'h01;
            ocd_pkg::IDX_C3_S1_COUNTS: chan3_stage1_counts <= pwdata[7:0];
            ocd_pkg::IDX_SRC_SEL: src_select <= pwdata[1:0];
            default: src_select <= src_select;
         endcase
      end
   end

   // ==========================================================================
   // stage configuration decode
   // ==========================================================================
   wire ocd_pkg::ocd_stage_cfg_s pecl_cfg;
   wire ocd_pkg::ocd_stage_cfg_s c2s1_cfg;
   wire ocd_pkg::ocd_stage_cfg_s c2s2_cfg;
   wire logic pecl_sync_hold;
   wire logic pecl_force_on;
   wire logic c2_sync_hold;
   wire logic c2_force_on;
   wire logic pecl_lvl;
   wire logic pecl_tick;
   wire logic s1_lvl;
   wire logic s1_tick;
   wire logic s2_lvl;

   // differential channel divider
   assign pecl_cfg.lo = ocd_pkg::upper_nib(pecl_div1_counts);
   assign pecl_cfg.hi = ocd_pkg::lower_nib(pecl_div1_counts);
   assign pecl_cfg.phase = ocd_pkg::lower_nib(pecl_div1_start_and_phase);
   assign pecl_cfg.bypass = pecl_div1_start_and_phase[ocd_pkg::PECL_BYPASS_BIT];
   assign pecl_cfg.start_hi = pecl_div1_start_and_phase[ocd_pkg::PECL_START_BIT];
   assign pecl_cfg.dcc_on = ~pecl_div1_route_and_duty[ocd_pkg::DCC_OFF_BIT];

   // cascaded channel two stages
   assign c2s1_cfg.lo = ocd_pkg::upper_nib(chan2_stage1_counts);
   assign c2s1_cfg.hi = ocd_pkg::lower_nib(chan2_stage1_counts);
   assign c2s1_cfg.phase = ocd_pkg::lower_nib(chan2_phase_offsets);
   assign c2s1_cfg.bypass = chan2_control[ocd_pkg::C2_BYPASS1_BIT];
   assign c2s1_cfg.start_hi = chan2_control[ocd_pkg::C2_START1_BIT];
   assign c2s1_cfg.dcc_on = ~chan2_duty_correction[ocd_pkg::DCC_OFF_BIT];
   assign c2s2_cfg.lo = ocd_pkg::upper_nib(chan2_stage2_counts);
   assign c2s2_cfg.hi = ocd_pkg::lower_nib(chan2_stage2_counts);
   assign c2s2_cfg.phase = ocd_pkg::upper_nib(chan2_phase_offsets);
   assign c2s2_cfg.bypass = chan2_control[ocd_pkg::C2_BYPASS2_BIT];
   assign c2s2_cfg.start_hi = chan2_control[ocd_pkg::C2_START2_BIT];
   assign c2s2_cfg.dcc_on = ~chan2_duty_correction[ocd_pkg::DCC_OFF_BIT];

   // sync gating: ignored channels see the forced level instead of a restart
   assign pecl_sync_hold = sync_req & ~pecl_div1_start_and_phase[ocd_pkg::PECL_NOSYNC_BIT];
   assign pecl_force_on = sync_req & pecl_div1_start_and_phase[ocd_pkg::PECL_NOSYNC_BIT];
   assign c2_sync_hold = sync_req & ~chan2_control[ocd_pkg::C2_NOSYNC_BIT];
   assign c2_force_on = sync_req & chan2_control[ocd_pkg::C2_NOSYNC_BIT];

   // ==========================================================================
   // distribution clock and stages
   // ==========================================================================
   // each ref_clk cycle is one divider input cycle; the toggle gives bypassed stages a level
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dist_lvl <= 1'b0;
      end else begin
         dist_lvl <= ~dist_lvl;
      end
   end

   ocd_div_stage u_pecl_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick_in(1'b1),
      .lvl_in(dist_lvl),
      .sync_hold(pecl_sync_hold),
      .force_on(pecl_force_on),
      .force_lvl(pecl_div1_start_and_phase[ocd_pkg::PECL_FORCE_BIT]),
      .cfg(pecl_cfg),
      .lvl_out(pecl_lvl),
      .tick_out(pecl_tick)
   );

   ocd_div_stage u_c2_stage1 (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick_in(1'b1),
      .lvl_in(dist_lvl),
      .sync_hold(c2_sync_hold),
      .force_on(c2_force_on),
      .force_lvl(chan2_control[ocd_pkg::C2_FORCE_BIT]),
      .cfg(c2s1_cfg),
      .lvl_out(s1_lvl),
      .tick_out(s1_tick)
   );

   // stage two advances on stage one rising edges, so ratios multiply; with stage one bypassed it advances every cycle
   ocd_div_stage u_c2_stage2 (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick_in(s1_tick),
      .lvl_in(s1_lvl),
      .sync_hold(c2_sync_hold),
      .force_on(c2_force_on),
      .force_lvl(chan2_control[ocd_pkg::C2_FORCE_BIT]),
      .cfg(c2s2_cfg),
      .lvl_out(s2_lvl),
      .tick_out()
   );

   // ==========================================================================
   // output pair routing
   // ==========================================================================
   // code 01 and the undefined 11 leave the divider in the path
   always_comb begin
      next_pair = pecl_lvl;
      if (pecl_div1_route_and_duty[ocd_pkg::ROUTE_DIRECT_BIT]) begin
         if (src_select == ocd_pkg::SRC_OSC) begin
            next_pair = osc_in;
         end else if (src_select == ocd_pkg::SRC_EXT) begin
            next_pair = ext_in;
         end else begin
            next_pair = pecl_lvl;
         end
      end
   end

   // output flops; one cycle of latency is traded for clean outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pair_b_true_output <= 1'b0;
         pair_b_comp_output <= 1'b1;
         chan2_clk_out <= 1'b0;
         chan2_stage1_out <= 1'b0;
      end else begin
         pair_b_true_output <= next_pair;
         pair_b_comp_output <= ~next_pair;
         chan2_clk_out <= s2_lvl;
         chan2_stage1_out <= s1_lvl;
      end
   end

   // pecl tick is only needed by a downstream stage this channel lacks
   wire logic unused_pecl_tick;
   assign unused_pecl_tick = pecl_tick;

endmodule

// ==== ocd_top_monitor.sv ====
// checker: apb handshake, sync freeze and output pair relations of the divider block
module ocd_top_monitor #(
   parameter int ADDR_W = 14
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_req,
   input wire logic osc_in,
   input wire logic ext_in,
   input wire logic pair_b_true_output,
   input wire logic pair_b_comp_output,
   input wire logic chan2_clk_out,
   input wire logic chan2_stage1_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // one clock domain, quiet while reset is high
   // ==========================================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // first access cycle, the edge where a request is taken
   wire acc_start = psel && penable && !pready;
   wire [11:0] idx = 12'(paddr[ADDR_W-1:2]);

   chk_ready_next: assert property (acc_start |=> pready)
      else $error("pready did not follow the first access cycle");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready stood longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside the answer cycle");
   chk_rdata_lane: assert property (prdata[31:8] == 24'h0)
      else $error("read data above the low byte");
   chk_unmapped_err: assert property (acc_start && idx == 12'h000 |=> pslverr)
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (acc_start && idx == ocd_pkg::IDX_C2_CTRL |=> !pslverr)
      else $error("mapped access refused");
   chk_pair_inverse: assert property (pair_b_comp_output == !pair_b_true_output)
      else $error("output pair sides not inverse");
   // margin of five samples covers the flop behind each stage level
   chk_sync_s1: assert property (sync_req [*5] |-> $stable(chan2_stage1_out))
      else $error("stage one moved while sync held");
   chk_sync_s2: assert property (sync_req [*5] |-> $stable(chan2_clk_out))
      else $error("stage two moved while sync held");

   cover property (acc_start && pwrite);
   cover property (pslverr);
   cover property (sync_req [*5]);
   cover property ($rose(pair_b_true_output));
endmodule

bind ocd_top ocd_top_monitor #(.ADDR_W(ADDR_W)) mon_u (.ref_clk(ref_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_req(sync_req),
   .osc_in(osc_in), .ext_in(ext_in), .pair_b_true_output(pair_b_true_output),
   .pair_b_comp_output(pair_b_comp_output), .chan2_clk_out(chan2_clk_out),
   .chan2_stage1_out(chan2_stage1_out));

// ==== ocd_top_tb_top.sv ====
// testbench: register map, divider waveforms, sync behaviour and output pair routing
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module ocd_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sync_req = 1'b0, osc_in = 1'b0, ext_in = 1'b0;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pb_t, pb_c, c2_out, c2_s1, er;
   logic [7:0] v, w;
   logic [3:0] ph;
   int err_count = 0, compares = 0, cyc = 0, hl, ll, h2, l2, n, n0, p;
   // register model: index, writable mask and shadow value
   logic [11:0] idx_q [$] = '{ocd_pkg::IDX_PECL1_COUNTS, ocd_pkg::IDX_PECL1_CTRL,
      ocd_pkg::IDX_PECL1_ROUTE, ocd_pkg::IDX_C2_S1_COUNTS, ocd_pkg::IDX_C2_PHASE,
      ocd_pkg::IDX_C2_S2_COUNTS, ocd_pkg::IDX_C2_CTRL, ocd_pkg::IDX_C2_DCC,
      ocd_pkg::IDX_C3_S1_COUNTS, ocd_pkg::IDX_SRC_SEL};
   logic [7:0] msk_q [$] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h01, 8'hff, 8'h03};
   logic [7:0] shadow [10];

   ocd_top dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sync_req(sync_req), .osc_in(osc_in), .ext_in(ext_in), .pair_b_true_output(pb_t),
      .pair_b_comp_output(pb_c), .chan2_clk_out(c2_out), .chan2_stage1_out(c2_s1));

   // ==========================================================================
   // clock and hang guard
   // ==========================================================================
   always #2 ref_clk = ~ref_clk;
   // the whole run needs a few thousand cycles, so this ceiling only trips on a hang
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         summarize();
      end
   end

   // ==========================================================================
   // tasks
   // ==========================================================================
   // apb transfer: request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, idx, d, q, e);
   endtask
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic sync_on;
      @(posedge ref_clk);
      sync_req <= 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
   endtask
   task automatic sync_off;
      @(posedge ref_clk);
      sync_req <= 1'b0;
   endtask
   task automatic resync;
      sync_on();
      sync_off();
   endtask
   function automatic logic lvl(input int s);
      return s == 0 ? c2_s1 : (s == 1 ? c2_out : pb_t);
   endfunction
   // one whole high run and the low run after it, in ref_clk cycles
   task automatic meas(input int s, output int h, output int l);
      h = 0;
      l = 0;
      while (lvl(s) !== 1'b0) tick();
      while (lvl(s) === 1'b0) tick();
      while (lvl(s) === 1'b1) begin h++; tick(); end
      while (lvl(s) === 1'b0) begin l++; tick(); end
   endtask
   task automatic summarize;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================================
   // main sequence
   // ==========================================================================
   initial begin
      void'($urandom(50));
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values, masked readback, then an unmapped place
      foreach (idx_q[i]) begin
         apb(1'b0, idx_q[i], 8'h0, rd, er);
         `CHK(rd, 32'h0)
         v = 8'($urandom);
         wr(idx_q[i], v);
         shadow[i] = v & msk_q[i];
         apb(1'b0, idx_q[i], 8'h0, rd, er);
         `CHK(rd, {24'h0, shadow[i]})
      end
      apb(1'b0, 12'h000, 8'h0, rd, er);
      `CHK({er, rd}, 33'h100000000)
      foreach (idx_q[i]) wr(idx_q[i], 8'h00);
      // start levels, then force only with sync ignore set
      wr(ocd_pkg::IDX_C2_DCC, 8'h01);
      for (int s = 0; s < 4; s++) begin
         wr(ocd_pkg::IDX_C2_CTRL, 8'(s));
         sync_on();
         `CHK(c2_s1, s[0])
         `CHK(c2_out, s[1])
         sync_off();
      end
      for (int f = 1; f < 4; f++) begin
         wr(ocd_pkg::IDX_C2_CTRL, 8'(f << 2));
         sync_on();
         `CHK(c2_s1, f == 3)
         `CHK(c2_out, f == 3)
         sync_off();
      end
      // counts with correction off, then on for stage one; stage two counts stage one periods
      wr(ocd_pkg::IDX_C2_CTRL, 8'h00);
      for (int k = 0; k < 3; k++) begin
         v = 8'($urandom);
         w = 8'($urandom) & 8'h33;
         p = v[3:0] + v[7:4] + 2;
         wr(ocd_pkg::IDX_C2_S1_COUNTS, v);
         wr(ocd_pkg::IDX_C2_S2_COUNTS, w);
         resync();
         meas(0, hl, ll);
         `CHK(hl, v[3:0] + 1)
         `CHK(ll, v[7:4] + 1)
         meas(1, h2, l2);
         `CHK(h2, (w[3:0] + 1) * p)
         `CHK(l2, (w[7:4] + 1) * p)
      end
      wr(ocd_pkg::IDX_C2_DCC, 8'h00);
      resync();
      meas(0, hl, ll);
      `CHK(hl, p / 2)
      `CHK(ll, p - p / 2)
      // phase offset shifts the first rise after sync release
      wr(ocd_pkg::IDX_C2_DCC, 8'h01);
      for (int k = 0; k < 2; k++) begin
         ph = k ? 4'($urandom_range(15, 1)) : 4'h0;
         wr(ocd_pkg::IDX_C2_PHASE, {4'h0, ph});
         resync();
         n = 0;
         do begin tick(); n++; end while (c2_s1 !== 1'b1);
         if (k == 0) n0 = n;
         else `CHK(n - n0, int'(ph))
      end
      // bypass: stage one toggles at half rate, stage two follows stage one
      wr(ocd_pkg::IDX_C2_CTRL, 8'h10);
      meas(0, hl, ll);
      `CHK(hl + ll, 2)
      wr(ocd_pkg::IDX_C2_CTRL, 8'h20);
      resync();
      meas(1, h2, l2);
      `CHK(h2, v[3:0] + 1)
      wr(ocd_pkg::IDX_C2_CTRL, 8'h00);
      // output pair: divider path, start level, then each direct source
      v = 8'($urandom);
      wr(ocd_pkg::IDX_PECL1_COUNTS, v);
      wr(ocd_pkg::IDX_PECL1_ROUTE, 8'h01);
      resync();
      meas(2, hl, ll);
      `CHK(hl, v[3:0] + 1)
      wr(ocd_pkg::IDX_PECL1_CTRL, 8'h10);
      sync_on();
      `CHK(pb_t, 1'b1)
      sync_off();
      wr(ocd_pkg::IDX_PECL1_ROUTE, 8'h03);
      for (int s = 0; s < 3; s++) begin
         wr(ocd_pkg::IDX_SRC_SEL, 8'(s));
         repeat (4) begin
            @(posedge ref_clk);
            osc_in <= 1'($urandom);
            ext_in <= 1'($urandom);
            repeat (3) tick();
            if (s != 1) `CHK(pb_t, s == 2 ? osc_in : ext_in)
         end
         // a direct source is static here, so only the divider path has edges to time
         if (s == 1) begin
            meas(2, hl, ll);
            `CHK(hl, v[3:0] + 1)
         end
      end
      summarize();
   end
endmodule
